//--- hw/hpd_defs.svh
// Purpose: Offsets, reset values, limits and timing figures of the hub power descriptor bank
// Assumes: Byte-wide configuration port, 40 MHz mclk
// Notes: Definitions only
`ifndef HPD_DEFS_SVH
`define HPD_DEFS_SVH

// Register offsets
`define HPD_ADDR_SP_UP_PWR 8'h0c
`define HPD_ADDR_BP_UP_PWR 8'h0d
`define HPD_ADDR_SP_CTL_CUR 8'h0e
`define HPD_ADDR_BP_CTL_CUR 8'h0f
`define HPD_ADDR_SETTLE 8'h10
`define HPD_ADDR_LANG_UPPER 8'h11
`define HPD_ADDR_LANG_LOWER 8'h12
`define HPD_ADDR_MAKER_LEN 8'h13

// Reset values
`define HPD_RST_SP_UP_PWR 8'h00
`define HPD_RST_BP_UP_PWR 8'h00
`define HPD_RST_SP_CTL_CUR 8'h32
`define HPD_RST_BP_CTL_CUR 8'h32
`define HPD_RST_SETTLE 8'h00
`define HPD_RST_LANG_UPPER 8'h00
`define HPD_RST_LANG_LOWER 8'h00
`define HPD_RST_MAKER_LEN 8'h00

// Limits in register units (2 mA per unit for power and current)
`define HPD_SP_CAP_UNITS 8'h32
`define HPD_MAKER_LEN_MAX 8'h1f

// Field positions of the language identifier
`define HPD_LANG_UPPER_LSB 8
`define HPD_LANG_LOWER_LSB 0

// Timing
`define HPD_SETTLE_UNIT_MS 2
`define HPD_MCLK_KHZ 40000
`define HPD_SETTLE_UNIT_CYCLES (`HPD_SETTLE_UNIT_MS * `HPD_MCLK_KHZ)

`endif

//--- hw/hpd_pkg.sv
// Purpose: Types shared by the hub power descriptor bank
// Assumes: Nothing beyond the defines header
// Notes: Constants live in hpd_defs.svh
package hpd_pkg;

  typedef enum logic [1:0] {
    HPD_SETTLE_IDLE,
    HPD_SETTLE_WAIT,
    HPD_SETTLE_DONE
  } hpd_settle_state_t;

  typedef struct packed {
    logic self_powered;
    logic [7:0] upstream_power;
    logic [8:0] upstream_power_ma;
    logic [7:0] controller_current;
    logic [8:0] controller_current_ma;
    logic [15:0] language_id;
    logic [7:0] maker_text_len;
  } hpd_desc_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hpd_cfg_req_t;

endpackage : hpd_pkg

//--- hw/hpd_settle_timer.sv
// Purpose: Port power settle timer counting whole settle units after a power-on start
// Assumes: start is a one-cycle pulse synchronous to mclk
// Notes: A start during a running wait restarts the wait
`timescale 1ns/100ps
module hpd_settle_timer #(
  parameter int TICK_CYCLES = 80000
) (
  input wire logic mclk, // Clock
  input wire logic reset, // Synchronous reset, high
  input wire logic start, // Power-on sequence begins
  input wire logic [7:0] units, // Settle time in units
  output logic stable // Port power is stable
);
  import hpd_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 1)
  begin : g_tick_check
    $error("hpd_settle_timer: TICK_CYCLES must be at least 1");
  end

  hpd_settle_state_t state;
  logic [TW-1:0] tick_cnt;
  logic [7:0] remain;
  logic tick_end;

  assign tick_end = (tick_cnt == TW'(TICK_CYCLES - 1));

  always_ff @(posedge mclk)
  begin
    if (reset)
      state <= HPD_SETTLE_IDLE;
    else if (start)
      state <= (units == 8'h00) ? HPD_SETTLE_DONE : HPD_SETTLE_WAIT;
    else
    begin
      unique case (state)
        HPD_SETTLE_IDLE: state <= HPD_SETTLE_IDLE;
        HPD_SETTLE_WAIT:
          if (tick_end && remain == 8'h01)
            state <= HPD_SETTLE_DONE;
        HPD_SETTLE_DONE: state <= HPD_SETTLE_DONE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset || start || state != HPD_SETTLE_WAIT || tick_end)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + TW'(1);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      remain <= 8'h00;
    else if (start)
      remain <= units;
    else if (state == HPD_SETTLE_WAIT && tick_end)
      remain <= remain - 8'h01;
  end

  assign stable = (state == HPD_SETTLE_DONE);

endmodule : hpd_settle_timer

//--- hw/hpd_config.sv
// Purpose: Hub power and descriptor configuration bank with settle timing
// Assumes: Loader writes bytes through the configuration port; mode input synchronous
// Notes: Descriptor outputs follow the stored bytes one cycle later
// Function
// - Bus-powered upstream consumption is reported as its byte times 2 mA.
// - Self-powered controller current is read in 2 mA units, attached peripherals excluded.
// - Self-powered controller current resets to 50 (100 mA) and is not meant to exceed it.
// - Bus-powered controller current is read in 2 mA units, silicon and board only.
// - Bus-powered controller current defaults to 50, that is 100 mA.
// - Port power settles after the settle byte times 2 ms from a power-on start.
// - The upper language byte forms bits 15 to 8 of the language identifier.
// - The lower language byte forms bits 7 to 0 of the language identifier.
// - Self-powered upstream consumption uses its own byte in 2 mA, capped at 100 mA.
`timescale 1ns/100ps
`include "hpd_defs.svh"
module hpd_config #(
  parameter int SETTLE_TICK_CYCLES = `HPD_SETTLE_UNIT_CYCLES
) (
  input wire logic mclk, // Clock, 40 MHz
  input wire logic reset, // Synchronous reset, high
  input wire hpd_pkg::hpd_cfg_req_t cfg_req, // Byte write or read request
  output logic [7:0] cfg_rdata, // Read data, registered
  output logic cfg_rvalid, // Read data valid pulse
  input wire logic self_powered, // Detected power mode, high when self-powered
  input wire logic port_power_start, // Host-initiated power-on begins
  output logic port_power_stable, // Port power has settled
  output hpd_pkg::hpd_desc_t desc // Figures for descriptor responses
);
  import hpd_pkg::*;

  if (SETTLE_TICK_CYCLES < 1)
  begin : g_tick_check
    $error("hpd_config: SETTLE_TICK_CYCLES must be at least 1");
  end
  // Both language bytes must land as whole bytes of the identifier
  if (`HPD_LANG_UPPER_LSB != `HPD_LANG_LOWER_LSB + 8)
  begin : g_lang_check
    $error("hpd_config: language byte positions must be eight bits apart");
  end

  logic [7:0] self_powered_upstream_power;
  logic [7:0] bus_powered_upstream_power;
  logic [7:0] self_powered_controller_current;
  logic [7:0] bus_powered_controller_current;
  logic [7:0] port_power_settle_delay;
  logic [7:0] language_code_upper;
  logic [7:0] language_code_lower;
  logic [7:0] maker_text_char_count;
  logic [7:0] next_rdata;
  hpd_desc_t next_desc;
  logic [7:0] sel_upstream_power;
  logic [7:0] sel_controller_current;

  // Register units are 2 mA each
  function automatic logic [8:0] hpd_units_to_ma(input logic [7:0] units);
    hpd_units_to_ma = {units, 1'b0};
  endfunction : hpd_units_to_ma

  function automatic logic [7:0] hpd_cap(input logic [7:0] v, input logic [7:0] lim);
    hpd_cap = (v > lim) ? lim : v;
  endfunction : hpd_cap

  function automatic logic hpd_wr_hit(input hpd_cfg_req_t r, input logic [7:0] a);
    hpd_wr_hit = r.wr && (r.addr == a);
  endfunction : hpd_wr_hit

  // Writes land at the edge that samples the strobe; unmapped offsets are ignored
  always_ff @(posedge mclk)
  begin
    if (reset)
      self_powered_upstream_power <= `HPD_RST_SP_UP_PWR;
    else if (hpd_wr_hit(cfg_req, `HPD_ADDR_SP_UP_PWR))
      self_powered_upstream_power <= cfg_req.wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      bus_powered_upstream_power <= `HPD_RST_BP_UP_PWR;
    else if (hpd_wr_hit(cfg_req, `HPD_ADDR_BP_UP_PWR))
      bus_powered_upstream_power <= cfg_req.wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      self_powered_controller_current <= `HPD_RST_SP_CTL_CUR;
    else if (hpd_wr_hit(cfg_req, `HPD_ADDR_SP_CTL_CUR))
      self_powered_controller_current <= cfg_req.wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      bus_powered_controller_current <= `HPD_RST_BP_CTL_CUR;
    else if (hpd_wr_hit(cfg_req, `HPD_ADDR_BP_CTL_CUR))
      bus_powered_controller_current <= cfg_req.wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      port_power_settle_delay <= `HPD_RST_SETTLE;
    else if (hpd_wr_hit(cfg_req, `HPD_ADDR_SETTLE))
      port_power_settle_delay <= cfg_req.wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      language_code_upper <= `HPD_RST_LANG_UPPER;
    else if (hpd_wr_hit(cfg_req, `HPD_ADDR_LANG_UPPER))
      language_code_upper <= cfg_req.wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      language_code_lower <= `HPD_RST_LANG_LOWER;
    else if (hpd_wr_hit(cfg_req, `HPD_ADDR_LANG_LOWER))
      language_code_lower <= cfg_req.wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      maker_text_char_count <= `HPD_RST_MAKER_LEN;
    else if (hpd_wr_hit(cfg_req, `HPD_ADDR_MAKER_LEN))
      maker_text_char_count <= cfg_req.wdata;
  end

  // Readback returns stored bytes as written; unmapped offsets read zero
  // A read and a write in the same cycle return the byte from before the write
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (cfg_req.addr)
      `HPD_ADDR_SP_UP_PWR: next_rdata = self_powered_upstream_power;
      `HPD_ADDR_BP_UP_PWR: next_rdata = bus_powered_upstream_power;
      `HPD_ADDR_SP_CTL_CUR: next_rdata = self_powered_controller_current;
      `HPD_ADDR_BP_CTL_CUR: next_rdata = bus_powered_controller_current;
      `HPD_ADDR_SETTLE: next_rdata = port_power_settle_delay;
      `HPD_ADDR_LANG_UPPER: next_rdata = language_code_upper;
      `HPD_ADDR_LANG_LOWER: next_rdata = language_code_lower;
      `HPD_ADDR_MAKER_LEN: next_rdata = maker_text_char_count;
      default: next_rdata = 8'h00;
    endcase
  end

  // Valid pulses for one cycle after each read strobe
  always_ff @(posedge mclk)
  begin
    if (reset)
      cfg_rvalid <= 1'b0;
    else
      cfg_rvalid <= cfg_req.rd;
  end

  // Read data holds the last answer until the next read
  always_ff @(posedge mclk)
  begin
    if (reset)
      cfg_rdata <= 8'h00;
    else if (cfg_req.rd)
      cfg_rdata <= next_rdata;
  end

  // Power mode picks which pair of figures is reported
  always_comb
  begin
    if (self_powered)
    begin
      // Self-powered figures are held to 100 mA whatever the loader wrote
      sel_upstream_power = hpd_cap(self_powered_upstream_power,
                                   `HPD_SP_CAP_UNITS);
      sel_controller_current = hpd_cap(self_powered_controller_current,
                                       `HPD_SP_CAP_UNITS);
    end
    else
    begin
      sel_upstream_power = bus_powered_upstream_power;
      sel_controller_current = bus_powered_controller_current;
    end
  end

  // Descriptor figures for the current power mode
  always_comb
  begin
    next_desc = '0;
    next_desc.self_powered = self_powered;
    next_desc.upstream_power = sel_upstream_power;
    next_desc.controller_current = sel_controller_current;
    next_desc.upstream_power_ma = hpd_units_to_ma(sel_upstream_power);
    next_desc.controller_current_ma = hpd_units_to_ma(sel_controller_current);
    next_desc.language_id[15:`HPD_LANG_UPPER_LSB] = language_code_upper;
    next_desc.language_id[7:`HPD_LANG_LOWER_LSB] = language_code_lower;
    // Readback stays raw; only the descriptor copy is held to 31 characters
    next_desc.maker_text_len = hpd_cap(maker_text_char_count, `HPD_MAKER_LEN_MAX);
  end

  // One cycle from stored bytes to descriptor figures
  always_ff @(posedge mclk)
  begin
    if (reset)
      desc <= '0;
    else
      desc <= next_desc;
  end

  // A start during a wait restarts it from the current settle byte
  hpd_settle_timer #(
    .TICK_CYCLES(SETTLE_TICK_CYCLES)
  ) u_settle (
    .mclk(mclk),
    .reset(reset),
    .start(port_power_start),
    .units(port_power_settle_delay),
    .stable(port_power_stable)
  );

endmodule : hpd_config

//--- hw/hpd_config_placeholder_none.sv
// Purpose: Holds no logic; the bank and its timer live in their own files
// Assumes: Nothing
// Notes: Kept only so the file list stays unchanged
`timescale 1ns/100ps

//--- dv/hpd_loader.sv
// Purpose: Loader model standing for the configuration memory or host
// Assumes: One byte request per call, driven on the falling edge
// Notes: Strobes drop after one cycle
`timescale 1ns/100ps
module hpd_loader (
  input wire logic mclk, // Clock
  output hpd_pkg::hpd_cfg_req_t req // Request to the bank
);
  import hpd_pkg::*;
  initial req = '0;
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req <= '{w, ~w, a, d};
    @(negedge mclk);
    req <= '0;
  endtask : put
endmodule : hpd_loader

//--- dv/hpd_config_assertions.sv
// Purpose: Port checks of the descriptor bank
// Assumes: One clock, synchronous reset
// Notes: Bound to every bank instance
`timescale 1ns/100ps
`include "hpd_defs.svh"
module hpd_config_assertions #(
  parameter int SETTLE_TICK_CYCLES = `HPD_SETTLE_UNIT_CYCLES
) (
  input wire logic mclk, // Clock
  input wire logic reset, // Reset
  input wire hpd_pkg::hpd_cfg_req_t cfg_req, // Request
  input wire logic [7:0] cfg_rdata, // Read data
  input wire logic cfg_rvalid, // Read valid
  input wire logic self_powered, // Mode
  input wire logic port_power_start, // Start
  input wire logic port_power_stable, // Stable
  input wire hpd_pkg::hpd_desc_t desc // Figures
);
  import hpd_pkg::*;
  int since_start;
  always_ff @(posedge mclk)
  begin
    since_start <= (reset || port_power_start) ? 0 : since_start + 1;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence s_wr_upper;
    cfg_req.wr && cfg_req.addr == `HPD_ADDR_LANG_UPPER ##1 !cfg_req.wr;
  endsequence
  sequence s_wr_lower;
    cfg_req.wr && cfg_req.addr == `HPD_ADDR_LANG_LOWER ##1 !cfg_req.wr;
  endsequence
  a_read_answered: assert property (
    cfg_req.rd |=> cfg_rvalid)
    else $error("read not answered");
  a_valid_has_cause: assert property (
    cfg_rvalid |-> $past(cfg_req.rd))
    else $error("read valid without read");
  a_lang_upper: assert property (
    s_wr_upper |=> desc.language_id[15:8] == $past(cfg_req.wdata, 2))
    else $error("upper language byte misplaced");
  a_lang_lower: assert property (
    s_wr_lower |=> desc.language_id[7:0] == $past(cfg_req.wdata, 2))
    else $error("lower language byte misplaced");
  a_mode_follows: assert property (
    !$past(reset) |-> desc.self_powered == $past(self_powered))
    else $error("mode not followed");
  a_power_scale: assert property (
    desc.upstream_power_ma == {desc.upstream_power, 1'b0})
    else $error("power not in 2 mA units");
  a_current_scale: assert property (
    desc.controller_current_ma == {desc.controller_current, 1'b0})
    else $error("current not in 2 mA units");
  a_self_cap: assert property (
    desc.self_powered |-> desc.upstream_power <= `HPD_SP_CAP_UNITS)
    else $error("self-powered power above cap");
  a_self_current: assert property (
    desc.self_powered |-> desc.controller_current <= `HPD_SP_CAP_UNITS)
    else $error("self-powered current above cap");
  a_settle_grid: assert property (
    $rose(port_power_stable) |-> since_start % SETTLE_TICK_CYCLES == 0)
    else $error("settle off the unit grid");
  a_stable_holds: assert property (
    port_power_stable && !port_power_start |=> port_power_stable)
    else $error("stable dropped");
endmodule : hpd_config_assertions
bind hpd_config hpd_config_assertions #(
  .SETTLE_TICK_CYCLES(SETTLE_TICK_CYCLES)
) hpd_config_assertions_inst (
  .mclk(mclk), .reset(reset), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .self_powered(self_powered), .port_power_start(port_power_start),
  .port_power_stable(port_power_stable), .desc(desc));

//--- dv/testbench.sv
// Purpose: Self-checking bench of the descriptor bank
// Assumes: Settle unit shortened to 4 cycles
// Notes: Inputs change on the falling edge
`timescale 1ns/100ps
`include "hpd_defs.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  import hpd_pkg::*;
  localparam int TICK = 4;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic self_powered = 1'b0;
  logic port_power_start = 1'b0;
  hpd_cfg_req_t cfg_req;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic port_power_stable;
  hpd_desc_t desc;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [7:0] vals [8] = '{8'h40, 8'h7d, 8'h28, 8'h96, 8'h02, 8'h04, 8'h09, 8'h1f};
  logic [7:0] rstv [8] = '{8'h00, 8'h00, 8'h32, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00};
  int units [3] = '{2, 0, 1};
  hpd_loader hpd_loader_inst (.mclk(mclk), .req(cfg_req));
  hpd_config #(.SETTLE_TICK_CYCLES(TICK)) hpd_config_inst (.mclk(mclk), .reset(reset),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .self_powered(self_powered), .port_power_start(port_power_start),
    .port_power_stable(port_power_stable), .desc(desc));
  initial forever #12.5 mclk = ~mclk;
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    hpd_loader_inst.put(1'b0, a, 8'h00);
    `CHK("read data", e, cfg_rdata)
    `CHK("read valid", 1'b1, cfg_rvalid)
  endtask : rd_chk
  task automatic settle(input int u);
    hpd_loader_inst.put(1'b1, `HPD_ADDR_SETTLE, 8'(u));
    port_power_start = 1'b1;
    @(negedge mclk);
    port_power_start = 1'b0;
    n = 0;
    while (port_power_stable !== 1'b1 && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    `CHK("settle cycles", u * TICK, n)
  endtask : settle
  task print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    foreach (rstv[i]) rd_chk(8'h0c + 8'(i), rstv[i]);
    `CHK("bp current", 9'd100, desc.controller_current_ma)
    foreach (vals[i]) hpd_loader_inst.put(1'b1, 8'h0c + 8'(i), vals[i]);
    hpd_loader_inst.put(1'b1, 8'h0b, 8'h55);
    foreach (vals[i]) rd_chk(8'h0c + 8'(i), vals[i]);
    rd_chk(8'h0b, 8'h00);
    rd_chk(8'h14, 8'h00);
    `CHK("bp power", 9'd250, desc.upstream_power_ma)
    `CHK("bp current", 9'd300, desc.controller_current_ma)
    `CHK("language", 16'h0409, desc.language_id)
    `CHK("maker length", 8'h1f, desc.maker_text_len)
    self_powered = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK("mode", 1'b1, desc.self_powered)
    `CHK("sp power", 9'd100, desc.upstream_power_ma)
    `CHK("sp current", 9'd80, desc.controller_current_ma)
    foreach (units[i]) settle(units[i]);
    reset = 1'b1;
    @(negedge mclk);
    reset = 1'b0;
    rd_chk(`HPD_ADDR_SP_CTL_CUR, `HPD_RST_SP_CTL_CUR);
    print_verdict;
  end
endmodule : testbench
